// ==== hdl/srs_pkg.sv ====
// Constants, command codes and carriers of the SDRAM read sequencer.
// Assumes one 100 MHz controller clock shared by all users.
package srs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int BANKS  = 4;
  localparam int BA_W   = 2;
  localparam int ROW_W  = 13;
  localparam int COL_W  = 10;
  localparam int A_W    = 13;
  localparam int DQ_W   = 16;
  localparam int LEN_W  = 4;
  localparam int BURST_LEN = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Modes and latency codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [1:0] CAS_CODE_2  = 2'h2;
  localparam logic [1:0] CAS_CODE_25 = 2'h1;
  localparam logic [1:0] CAS_CODE_3  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRP_NS        = 20;
  localparam int TRCD_NS       = 20;
  localparam int TRP_CYC  = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRCD_CYC = (TRCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Commands: {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_NOP  = 4'h7,
    CMD_PRE  = 4'h2,
    CMD_ACT  = 4'h3,
    CMD_READ = 4'h5,
    CMD_BST  = 4'h6
  } srs_cmd_e;

  localparam srs_cmd_e CMD_RESET = CMD_NOP;

  typedef struct packed {
    logic [BA_W-1:0]  bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [LEN_W-1:0] len;
  } srs_req_s;

  typedef struct packed {
    srs_cmd_e         cmd;
    logic [BA_W-1:0]  bank;
    logic [A_W-1:0]   addr;
  } srs_cmd_s;

endpackage

// ==== hdl/srs_buf2.sv ====
// Two-entry buffer with valid/ready on both sides; outputs from flops.
// Assumes both sides on the same clock and a synchronous high reset.
`timescale 1ns/1ps
module srs_buf2 #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Fill side
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);

  logic         vld1;
  logic [W-1:0] tail;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes; full refuses even on a pop to keep ready flop-only
  assign in_ready = !vld1;
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;

  // Head is the output word, tail the overflow slot
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      vld1      <= 1'b0;
      out_data  <= '0;
      tail      <= '0;
    end else if (push && pop) begin
      out_data <= in_data;
    end else if (pop) begin
      out_data  <= tail;
      out_valid <= vld1;
      vld1      <= 1'b0;
    end else if (push) begin
      if (!out_valid) begin
        out_data  <= in_data;
        out_valid <= 1'b1;
      end else begin
        tail <= in_data;
        vld1 <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A stalled word holds still
  property p_hold;
    @(posedge clk) disable iff (srst)
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer word changed");

endmodule

// ==== hdl/srs_read_seq.sv ====
// Read-path command sequencer of an SDRAM memory controller.
// Assumes the SDRAM is set for burst 8 and the same latency as CAS_LAT.
`timescale 1ns/1ps
module srs_read_seq (
  // Clock and reset
  input  wire logic                       CLOCK,
  input  wire logic                       SRST,
  // Configuration
  input  wire logic [2:0]                 MODE,
  input  wire logic [1:0]                 CAS_LAT,
  // Read request
  input  wire logic                       REQ_VALID,
  output      logic                       REQ_READY,
  input  wire logic [srs_pkg::BA_W-1:0]   REQ_BANK,
  input  wire logic [srs_pkg::ROW_W-1:0]  REQ_ROW,
  input  wire logic [srs_pkg::COL_W-1:0]  REQ_COL,
  input  wire logic [srs_pkg::LEN_W-1:0]  REQ_LEN,
  // Read data
  output      logic                       RD_VALID,
  input  wire logic                       RD_READY,
  output      logic [srs_pkg::DQ_W-1:0]   RD_DATA,
  // SDRAM pins
  output      logic [3:0]                 SD_CMD,
  output      logic [srs_pkg::BA_W-1:0]   SD_BA,
  output      logic [srs_pkg::A_W-1:0]    SD_A,
  input  wire logic [srs_pkg::DQ_W-1:0]   SD_DQ_IN,
  output      logic [srs_pkg::DQ_W-1:0]   SD_DQ_OUT,
  output      logic                       SD_DQ_OE_N
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_TRP   = 4'h2,
    ST_RDISS = 4'h4,
    ST_DATA  = 4'h8
  } srs_state_e;

  // Capture delay in cycles for a latency code; 2.5 rounds up
  function automatic logic [2:0] cas_cycles(input logic [1:0] code);
    if (code == srs_pkg::CAS_CODE_2) begin
      cas_cycles = 3'h2;
    end else begin
      cas_cycles = 3'h3;
    end
  endfunction

  srs_state_e                   state;
  srs_state_e                   next_state;
  srs_pkg::srs_cmd_s            cmd_q;
  srs_pkg::srs_cmd_s            next_cmd;
  srs_pkg::srs_req_s            req_q;
  logic [srs_pkg::ROW_W-1:0]    open_row [srs_pkg::BANKS];
  logic [srs_pkg::BANKS-1:0]    open_vld;
  logic [2:0]                   wait_cnt;
  logic [3:0]                   icnt;
  logic [3:0]                   beats_q;
  logic [3:0]                   beats_left;
  logic [3:0]                   stored;
  logic                         dropping;
  logic                         bst_done;
  logic [srs_pkg::DQ_W-1:0]     dq_meta;
  logic [srs_pkg::DQ_W-1:0]     dq_sync;
  logic                         accept;
  logic                         page_hit;
  logic                         take;
  logic                         push;
  logic                         buf_ready;
  logic                         last_take;
  logic [3:0]                   stored_next;
  logic [srs_pkg::COL_W-1:0]    rd_col;
  logic [3:0]                   remain;
  logic [3:0]                   room;
  logic [3:0]                   nbeats;

  ////////////////////////////////////////////////////////////////////////////
  // Request side decode
  assign accept   = REQ_VALID && REQ_READY;
  assign page_hit = open_vld[REQ_BANK] && (open_row[REQ_BANK] == REQ_ROW);

  // Beat window and next column; a burst never wraps its 8-column group
  assign take        = (state == ST_DATA) && (wait_cnt == 3'h0)
                       && (beats_left != 4'h0);
  assign push        = take && buf_ready && !dropping;
  assign last_take   = take && (beats_left == 4'h1);
  assign stored_next = push ? stored + 4'h1 : stored;
  assign rd_col      = req_q.col + srs_pkg::COL_W'(stored);
  assign remain      = req_q.len - stored;
  assign room        = 4'h8 - {1'b0, rd_col[2:0]};
  assign nbeats      = (remain < room) ? remain : room;

  ////////////////////////////////////////////////////////////////////////////
  // Next state and next command
  always_comb begin
    next_state    = state;
    next_cmd      = cmd_q;
    next_cmd.cmd  = srs_pkg::CMD_NOP;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          if (page_hit) begin
            next_state = ST_RDISS;
          end else begin
            next_cmd.cmd  = srs_pkg::CMD_PRE;
            next_cmd.bank = REQ_BANK;
            next_cmd.addr = '0;
            next_state    = ST_TRP;
          end
        end
      end
      ST_TRP: begin
        if (wait_cnt == 3'h0) begin
          next_cmd.cmd  = srs_pkg::CMD_ACT;
          next_cmd.bank = req_q.bank;
          next_cmd.addr = req_q.row;
          next_state    = ST_RDISS;
        end
      end
      ST_RDISS: begin
        // Waits for row-to-column time and for room in the buffer
        if ((wait_cnt == 3'h0) && buf_ready) begin
          next_cmd.cmd  = srs_pkg::CMD_READ;
          next_cmd.bank = req_q.bank;
          next_cmd.addr = srs_pkg::A_W'(rd_col);
          next_state    = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!bst_done && (beats_q < 4'h8) && (icnt == beats_q)) begin
          next_cmd.cmd = srs_pkg::CMD_BST;
        end
        if (last_take) begin
          // Dropped beats are read again from the open row
          next_state = (stored_next == req_q.len) ? ST_IDLE : ST_RDISS;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, request latch and ready
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state     <= ST_IDLE;
      req_q     <= '0;
      REQ_READY <= 1'b0;
    end else begin
      state     <= next_state;
      REQ_READY <= (next_state == ST_IDLE)
                   && (MODE == srs_pkg::MODE_NORMAL);
      if (accept) begin
        req_q <= '{bank: REQ_BANK, row: REQ_ROW, col: REQ_COL, len: REQ_LEN};
      end
    end
  end

  // Command pins, registered so the SDRAM sees clean levels
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cmd_q <= '{cmd: srs_pkg::CMD_RESET, bank: '0, addr: '0};
    end else begin
      cmd_q <= next_cmd;
    end
  end

  // Wait counter: precharge, row-to-column and capture delays
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wait_cnt <= 3'h0;
    end else if (accept) begin
      wait_cnt <= page_hit ? 3'h0 : 3'(srs_pkg::TRP_CYC - 1);
    end else if (next_cmd.cmd == srs_pkg::CMD_ACT) begin
      wait_cnt <= 3'(srs_pkg::TRCD_CYC - 1);
    end else if (next_cmd.cmd == srs_pkg::CMD_READ) begin
      wait_cnt <= cas_cycles(CAS_LAT)
                  + 3'(srs_pkg::SYNC_STAGES - 1);
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end
  end

  // Burst bookkeeping: beats asked, beats left, beats kept
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      icnt       <= 4'h0;
      beats_q    <= 4'h0;
      beats_left <= 4'h0;
      stored     <= 4'h0;
      dropping   <= 1'b0;
      bst_done   <= 1'b0;
    end else begin
      if (accept) begin
        stored <= 4'h0;
      end else begin
        stored <= stored_next;
      end
      if (next_cmd.cmd == srs_pkg::CMD_READ) begin
        icnt       <= 4'h1;
        beats_q    <= nbeats;
        beats_left <= 4'(srs_pkg::BURST_LEN);
        dropping   <= 1'b0;
        bst_done   <= 1'b0;
      end else begin
        if (icnt != 4'hF) begin
          icnt <= icnt + 4'h1;
        end
        if (next_cmd.cmd == srs_pkg::CMD_BST) begin
          bst_done <= 1'b1;
        end
        if (take) begin
          beats_left <= beats_left - 4'h1;
        end
        // Once a beat is lost the rest of the burst is re-read instead
        if (take && !buf_ready) begin
          dropping <= 1'b1;
        end
      end
      // Only the requested beats count; a stopped tail is ignored
      if ((next_cmd.cmd == srs_pkg::CMD_READ) || (state != ST_DATA)) begin
        beats_left <= (next_cmd.cmd == srs_pkg::CMD_READ) ? nbeats : 4'h0;
      end
    end
  end

  // Open row table, updated with the command that changes it
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      open_vld <= '0;
      for (int i = 0; i < srs_pkg::BANKS; i++) begin
        open_row[i] <= '0;
      end
    end else if (next_cmd.cmd == srs_pkg::CMD_PRE) begin
      open_vld[next_cmd.bank] <= 1'b0;
    end else if (next_cmd.cmd == srs_pkg::CMD_ACT) begin
      open_vld[next_cmd.bank] <= 1'b1;
      open_row[next_cmd.bank] <= next_cmd.addr;
    end
  end

  // Data pins pass two flops before the capture window reads them
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      dq_meta <= '0;
      dq_sync <= '0;
    end else begin
      dq_meta <= SD_DQ_IN;
      dq_sync <= dq_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffer; a stalled receiver makes the sequencer re-read
  srs_buf2 #(
    .W(srs_pkg::DQ_W)
  ) u_buf (
    .clk      (CLOCK),
    .srst     (SRST),
    .in_valid (push),
    .in_ready (buf_ready),
    .in_data  (dq_sync),
    .out_valid(RD_VALID),
    .out_ready(RD_READY),
    .out_data (RD_DATA)
  );

  // Pin outputs straight from the command flops; reads never drive DQ
  assign SD_CMD     = cmd_q.cmd;
  assign SD_BA      = cmd_q.bank;
  assign SD_A       = cmd_q.addr;
  assign SD_DQ_OUT  = '0;
  assign SD_DQ_OE_N = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_mode;
    @(posedge CLOCK) disable iff (SRST)
    REQ_READY |-> $past(MODE) == srs_pkg::MODE_NORMAL;
  endproperty
  a_mode: assert property (p_mode) else $error("ready outside normal mode");

  property p_row;
    @(posedge CLOCK) disable iff (SRST)
    SD_CMD == srs_pkg::CMD_ACT |-> open_vld[SD_BA] && open_row[SD_BA] == SD_A;
  endproperty
  a_row: assert property (p_row) else $error("open row not recorded");

  property p_full;
    @(posedge CLOCK) disable iff (SRST)
    SD_CMD == srs_pkg::CMD_READ && beats_q == 4'h8
      |=> (SD_CMD != srs_pkg::CMD_BST) [*8];
  endproperty
  a_full: assert property (p_full) else $error("full burst was stopped");

  property p_cas;
    @(posedge CLOCK) disable iff (SRST)
    take && beats_left == beats_q
      |-> icnt == 4'(cas_cycles(CAS_LAT)) + 4'(srs_pkg::SYNC_STAGES);
  endproperty
  a_cas: assert property (p_cas) else $error("capture off latency");

  property p_hit;
    @(posedge CLOCK) disable iff (SRST)
    accept && page_hit |=> state == ST_RDISS && SD_CMD == srs_pkg::CMD_NOP;
  endproperty
  a_hit: assert property (p_hit) else $error("page hit changed page");

  property p_miss;
    @(posedge CLOCK) disable iff (SRST)
    accept && !page_hit |=> SD_CMD == srs_pkg::CMD_PRE && SD_BA == req_q.bank;
  endproperty
  a_miss: assert property (p_miss) else $error("miss without precharge");

  property p_trp;
    @(posedge CLOCK) disable iff (SRST)
    SD_CMD == srs_pkg::CMD_PRE
      |=> SD_CMD == srs_pkg::CMD_NOP ##1 SD_CMD == srs_pkg::CMD_ACT;
  endproperty
  a_trp: assert property (p_trp) else $error("precharge time broken");

  property p_trcd;
    @(posedge CLOCK) disable iff (SRST)
    SD_CMD == srs_pkg::CMD_ACT
      |=> SD_CMD == srs_pkg::CMD_NOP ##[1:200] SD_CMD == srs_pkg::CMD_READ;
  endproperty
  a_trcd: assert property (p_trcd) else $error("row-to-column broken");

  property p_bst;
    @(posedge CLOCK) disable iff (SRST)
    SD_CMD == srs_pkg::CMD_BST |-> beats_q < 4'h8 && icnt == beats_q + 4'h1;
  endproperty
  a_bst: assert property (p_bst) else $error("burst stop misplaced");

  property p_more;
    @(posedge CLOCK) disable iff (SRST)
    last_take && stored_next != req_q.len |=> state == ST_RDISS;
  endproperty
  a_more: assert property (p_more) else $error("request ended short");

endmodule

// ==== tb/srs_sdram_model.sv ====
// Behavioural SDRAM device facing the read sequencer on its command pins.
// Assumes burst 8, sequential order, latency taken from the same code pins.
`timescale 1ns/1ps
module srs_sdram_model (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     srst,
  // Command pins and latency code
  input  wire logic [3:0]               sd_cmd,
  input  wire logic [srs_pkg::BA_W-1:0] sd_ba,
  input  wire logic [srs_pkg::A_W-1:0]  sd_a,
  input  wire logic [1:0]               cas_lat,
  // Data pins and protocol fault count
  output      logic [srs_pkg::DQ_W-1:0] sd_dq,
  output      int                       err_cnt
);
  logic [15:0] beat_q [int];
  logic [12:0] open_row [4];
  logic        open_v [4];
  int          last_pre [4];
  int          last_act [4];
  int          cyc;
  int          cl;

  ////////////////////////////////////////////////////////////////////////////
  // Stored word pattern, unique per bank, low four row bits and column
  function automatic logic [15:0] word(input logic [1:0] b,
                                       input logic [12:0] r,
                                       input logic [9:0] c);
    return {b, r[3:0], c};
  endfunction

  initial begin
    sd_dq = 16'h0000;
    err_cnt = 0;
    cyc = 0;
    last_pre = '{default: -100};
    last_act = '{default: -100};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; a command seen here left the controller one edge ago
  always @(posedge clk) begin
    cyc = cyc + 1;
    cl = (cas_lat == 2'h2) ? 2 : 3;
    if (srst) begin
      beat_q.delete();
      open_v = '{default: 1'b0};
    end else begin
      case (sd_cmd)
        4'h2: begin
          open_v[sd_ba] = 1'b0;
          last_pre[sd_ba] = cyc;
        end
        4'h3: begin
          // Row open twice or precharge time cut short
          if (open_v[sd_ba] || cyc - last_pre[sd_ba] < 2) begin
            err_cnt++;
          end
          open_v[sd_ba] = 1'b1;
          open_row[sd_ba] = sd_a;
          last_act[sd_ba] = cyc;
        end
        4'h5: begin
          if (!open_v[sd_ba] || cyc - last_act[sd_ba] < 2) begin
            err_cnt++;
          end
          // Eight beats, wrapping inside the aligned group of eight
          for (int i = 0; i < 8; i++) begin
            beat_q[cyc - 1 + cl + i] = word(sd_ba, open_row[sd_ba],
              {sd_a[9:3], sd_a[2:0] + 3'(i)});
          end
        end
        4'h6: begin
          // Burst stop silences the beats due cl or more cycles after the stop left the controller
          for (int k = cyc - 1 + cl; k < cyc + cl + 8; k++) begin
            if (beat_q.exists(k)) begin
              beat_q.delete(k);
            end
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins change mid-cycle; idle pins toggle so stale data never matches
  always @(negedge clk) begin
    if (beat_q.exists(cyc + 1)) begin
      sd_dq = beat_q[cyc + 1];
      beat_q.delete(cyc + 1);
    end else begin
      sd_dq = ~sd_dq;
    end
  end
endmodule

// ==== tb/sdram_read_cycle_sequencer_bench.sv ====
// Self-checking bench for the SDRAM read sequencer with a device model.
// Assumes the package constants and the hand-over timing of the sequencer.
`timescale 1ns/1ps
module sdram_read_cycle_sequencer_bench;
  logic              clock;
  logic              srst;
  logic [2:0]        mode;
  logic [1:0]        cas_lat;
  logic              req_valid;
  logic              req_ready;
  srs_pkg::srs_req_s req;
  logic              rd_valid;
  logic              rd_ready;
  logic [15:0]       rd_data;
  logic [3:0]        sd_cmd;
  logic [1:0]        sd_ba;
  logic [12:0]       sd_a;
  logic [15:0]       sd_dq_in;
  logic [15:0]       sd_dq_out;
  logic              sd_dq_oe_n;
  int                model_err;
  int                n_errors = 0;
  int                checks_done = 0;
  int                n_pre;
  int                n_act;
  int                n_rd;
  int                n_bst;
  bit                stall;
  logic [15:0]       exp_q [$];
  logic [12:0]       row_tab [4];
  bit                row_ok [4];

  srs_read_seq srs_read_seq_i (
    .CLOCK(clock), .SRST(srst), .MODE(mode), .CAS_LAT(cas_lat),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_BANK(req.bank),
    .REQ_ROW(req.row), .REQ_COL(req.col), .REQ_LEN(req.len),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
    .SD_CMD(sd_cmd), .SD_BA(sd_ba), .SD_A(sd_a), .SD_DQ_IN(sd_dq_in),
    .SD_DQ_OUT(sd_dq_out), .SD_DQ_OE_N(sd_dq_oe_n)
  );

  srs_sdram_model srs_sdram_model_i (
    .clk(clock), .srst(srst), .sd_cmd(sd_cmd), .sd_ba(sd_ba), .sd_a(sd_a),
    .cas_lat(cas_lat), .sd_dq(sd_dq_in), .err_cnt(model_err)
  );

  // 100 MHz clock
  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_int(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read commands per request; with stop set, only those cut short count
  function automatic int n_chunks(input int col, input int len,
                                  input bit stop);
    int n;
    int cnt;
    cnt = 0;
    while (len > 0) begin
      n = 8 - col % 8;
      if (n > len) n = len;
      if (!stop || n < 8) cnt++;
      col += n;
      len -= n;
    end
    return cnt;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command counters and data sink
  always @(posedge clock) begin
    if (!srst) begin
      if (sd_cmd == srs_pkg::CMD_PRE) n_pre++;
      if (sd_cmd == srs_pkg::CMD_ACT) n_act++;
      if (sd_cmd == srs_pkg::CMD_READ) n_rd++;
      if (sd_cmd == srs_pkg::CMD_BST) n_bst++;
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        chk_int("beat queued", 1, (exp_q.size() > 0) ? 1 : 0);
        if (exp_q.size() > 0) begin
          chk16("rd_data", exp_q.pop_front(), rd_data);
        end
      end
    end
  end

  // Receiver stalls at random while stall is set, so the buffer fills up
  always @(negedge clock) begin
    rd_ready <= stall ? ($urandom % 4 == 0) : 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One request; blk first holds the mode off normal and expects refusal
  task automatic do_req(input logic [1:0] b, input logic [12:0] r,
                        input logic [9:0] c, input logic [3:0] len,
                        input bit blk);
    bit hit;
    int k;
    hit = row_ok[b] && row_tab[b] == r;
    for (int j = 0; j < len; j++) exp_q.push_back({b, r[3:0], c + 10'(j)});
    n_pre = 0;
    n_act = 0;
    n_rd = 0;
    n_bst = 0;
    @(negedge clock);
    if (blk) begin
      mode = 3'h5;
      repeat (2) @(negedge clock);
    end
    req_valid = 1'b1;
    req = '{bank: b, row: r, col: c, len: len};
    if (blk) begin
      repeat (4) @(negedge clock);
      chk16("req_ready", 16'h0000, 16'(req_ready));
      chk_int("cmds refused", 0, n_pre + n_act + n_rd);
      mode = srs_pkg::MODE_NORMAL;
    end
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    while ((req_ready !== 1'b1 || exp_q.size() > 0) && k < 500) begin
      @(negedge clock);
      k++;
    end
    chk_int("request done", 1, (k < 500) ? 1 : 0);
    chk_int("precharges", hit ? 0 : 1, n_pre);
    chk_int("activates", hit ? 0 : 1, n_act);
    if (!stall) begin
      chk_int("reads", n_chunks(c, len, 0), n_rd);
      chk_int("burst stops", n_chunks(c, len, 1), n_bst);
    end
    row_tab[b] = r;
    row_ok[b] = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: every latency code, corner requests, then random ones
  initial begin
    void'($urandom(77));
    clock = 1'b0;
    srst = 1'b1;
    mode = srs_pkg::MODE_NORMAL;
    cas_lat = srs_pkg::CAS_CODE_2;
    req_valid = 1'b0;
    req = '0;
    rd_ready = 1'b1;
    stall = 1'b0;
    for (int code = 0; code < 4; code++) begin
      @(negedge clock);
      srst = 1'b1;
      cas_lat = 2'(code);
      row_ok = '{default: 1'b0};
      repeat (4) @(negedge clock);
      srst = 1'b0;
      repeat (2) @(negedge clock);
      do_req(2'h0, 13'h0005, 10'h000, 4'h1, 1'b0);
      do_req(2'h0, 13'h0005, 10'h007, 4'h2, 1'b1);
      do_req(2'h1, 13'h0005, 10'h008, 4'h8, 1'b0);
      do_req(2'h0, 13'h0005, 10'h3F1, 4'hF, 1'b0);
      do_req(2'h0, 13'h0006, 10'h000, 4'h8, 1'b0);
      stall = (code % 2 == 1);
      repeat (30) begin
        do_req(2'($urandom), 13'($urandom % 3), 10'($urandom % 1009),
               4'($urandom % 15 + 1), ($urandom % 8) == 0);
      end
      stall = 1'b0;
    end
    chk_int("model faults", 0, model_err);
    chk16("dq_oe_n", 16'h0001, 16'(sd_dq_oe_n));
    chk16("dq_out", 16'h0000, sd_dq_out);
    end_of_test();
  end

  // Watchdog: 140 requests at 500 cycles worst case, plus margin
  initial begin
    #800000;
    chk_int("watchdog", 0, 1);
    end_of_test();
  end
endmodule
